/* File: drive_ctl_pkg.sv */
// Overview of operation
// RL1: No-fault output high only in states 4-6; active output high only in 6.
// RL2: State word bits 0-3 give operating state 1-9; bits 4,5,9-12 reserved.
// RL3: State word bit 6 is set while a class 1 to 3 error is detected.
// RL4: Bit 7 flags a class 0 warning; bit 8 is set while halt is active.
// RL5: Bit 13 mode info, bit 14 mode started/terminated, bit 15 mode error.
// RL6: Enable pin rising edge requests enabling; falling edge requests disabling.
// RL7: Fault reset pin rising edge requests error reset (9 to 3, 7 to 6).
// RL8: Command bit 0 disables power stage (6 to 4); bit 1 enables (4 to 6).
// RL9: Command bit 2 quick stop (6 to 7); bit 3 fault reset; bit 4 reserved.
// RL10: In state 6 bit 5 sets halt, bit 6 clears halt, bit 7 resumes.
// RL11: Each command bit acts only on a 0-to-1 change against its last value.
// RL12: Requests that cannot be carried out are silently dropped.
// RL13: Writing all eight command bits as zero disables the power stage.
// RL14: Disable wins over a simultaneous enable request.
// RL15: Quick stop wins over a simultaneous fault reset request; code masks only the command fault reset, not the pin.
// RL16: Set-halt wins over simultaneous clear-halt and resume requests.
// RL17: After class 2 or 3 error, fault reset needs enable command bit at 0; code checks this only for the command fault reset.
// RL18: Mode state bits 0-3 report the set mode code; bit 4 reserved.
// RL19: Mode state bit 5 is set while the zero point is valid.
// RL20: Mode state bit 6 flags a rejected mode request; bit 7 is the toggle.
// RL21: Controller puts mode code in bits 0-3 and action in bits 4-6.
// RL22: Controller supplies targets, mode and action, then toggles bit 7.
// RL23: Enable moves state 4 to 5, then automatically to 6 with power on.
// RL24: Fault reset in 9 needs cause corrected; in 7 it returns to 6.
// RL25: New mode starts only when the toggle differs from the last acted value.
// RL26: Reserved status bits read zero; writes to reserved command bits do nothing.
package drive_ctl_pkg;

  typedef enum logic [8:0] {
    ST_START    = 9'h001,
    ST_NOT_RDY  = 9'h002,
    ST_SW_DIS   = 9'h004,
    ST_RDY      = 9'h008,
    ST_SW_ON    = 9'h010,
    ST_OP_EN    = 9'h020,
    ST_QSTOP    = 9'h040,
    ST_FLT_REAC = 9'h080,
    ST_FAULT    = 9'h100
  } op_state_e;

  localparam int unsigned SW_STATE_LSB = 0;
  localparam int unsigned SW_ERROR_BIT = 6;
  localparam int unsigned SW_WARN_BIT  = 7;
  localparam int unsigned SW_HALT_BIT  = 8;
  localparam int unsigned SW_INFO_BIT  = 13;
  localparam int unsigned SW_END_BIT   = 14;
  localparam int unsigned SW_MERR_BIT  = 15;

  localparam int unsigned CB_POWER_OFF = 0;
  localparam int unsigned CB_POWER_ON  = 1;
  localparam int unsigned CB_QSTOP     = 2;
  localparam int unsigned CB_FCLR      = 3;
  localparam int unsigned CB_HSET      = 5;
  localparam int unsigned CB_HCLR      = 6;
  localparam int unsigned CB_RESUME    = 7;
  localparam logic [7:0]  CB_VALID     = 8'hef;

  localparam int unsigned MC_MODE_LSB  = 0;
  localparam int unsigned MC_ACT_LSB   = 4;
  localparam int unsigned MS_REF_BIT   = 5;
  localparam int unsigned MS_REJ_BIT   = 6;
  localparam int unsigned MS_TOG_BIT   = 7;

  localparam logic [15:0] STATE_WORD_RST = 16'h0000;
  localparam logic [7:0]  MODE_STATE_RST = 8'h00;
  localparam logic [7:0]  CMD_PREV_RST   = 8'h00;
  localparam logic [3:0]  MODE_CODE_RST  = 4'h0;

  function automatic logic [3:0] state_code(input op_state_e s);
    case (s)
      ST_START:    state_code = 4'h1;
      ST_NOT_RDY:  state_code = 4'h2;
      ST_SW_DIS:   state_code = 4'h3;
      ST_RDY:      state_code = 4'h4;
      ST_SW_ON:    state_code = 4'h5;
      ST_OP_EN:    state_code = 4'h6;
      ST_QSTOP:    state_code = 4'h7;
      ST_FLT_REAC: state_code = 4'h8;
      ST_FAULT:    state_code = 4'h9;
      default:     state_code = 4'h0;
    endcase
  endfunction

endpackage

/* File: pin_edge.sv */
`timescale 1ns/1ns
module pin_edge (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Two-stage synchroniser, then edge detect on the second stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule

/* File: drive_state_mode_control.sv */
`timescale 1ns/1ns
module drive_state_mode_control
  import drive_ctl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        enable_pin,
  input  wire logic        fault_reset_pin,
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        mode_wr,
  input  wire logic [7:0]  mode_data,
  input  wire logic        init_done,
  input  wire logic        param_done,
  input  wire logic        supply_ok,
  input  wire logic        supply_lost,
  input  wire logic        err_detect,
  input  wire logic        warn_detect,
  input  wire logic        err_class1_evt,
  input  wire logic        err_severe_evt,
  input  wire logic        err_class23,
  input  wire logic        err_resp_done,
  input  wire logic        cause_corrected,
  input  wire logic        mode_specific_info,
  input  wire logic        mode_ended,
  input  wire logic        mode_err,
  input  wire logic        ref_valid,
  input  wire logic        mode_reject,
  output logic [15:0]      drive_state_word,
  output logic [7:0]       mode_state_byte,
  output logic             no_fault_out,
  output logic             active_out,
  output logic             power_stage_on,
  output logic             halt_active,
  output logic             resume_pulse,
  output logic             mode_start,
  output logic [3:0]       mode_code,
  output logic [2:0]       mode_action
);

  op_state_e   state_q;
  op_state_e   state_d;
  logic [7:0]  cmd_prev_q;
  logic [7:0]  cmd_rise;
  logic        cmd_zero;
  logic        en_rise;
  logic        en_fall;
  logic        fr_rise;
  logic        off_cmd;
  logic        off_pin;
  logic        on_req;
  logic        qstop_req;
  logic        fclr_cmd;
  logic        fclr_pin;
  logic        severe23_q;
  logic        halt_q;
  logic        tog_q;
  logic        reject_q;
  logic        mode_new;

  pin_edge u_enable_edge (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  (enable_pin),
    .rise    (en_rise),
    .fall    (en_fall)
  );

  pin_edge u_fclr_edge (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  (fault_reset_pin),
    .rise    (fr_rise),
    .fall    ()
  );

  // Command edge detection against last written value
  assign cmd_rise = cmd_wr ? (cmd_data & ~cmd_prev_q & CB_VALID) : 8'h00; // RL11 RL26
  assign cmd_zero = cmd_wr && (cmd_data == 8'h00);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_prev_q <= CMD_PREV_RST;
    end else if (cmd_wr) begin
      cmd_prev_q <= cmd_data & CB_VALID; // RL11
    end
  end

  // Request arbitration
  assign off_cmd   = cmd_rise[CB_POWER_OFF] | cmd_zero; // RL8 RL13
  assign off_pin   = en_fall; // RL6
  assign on_req    = (cmd_rise[CB_POWER_ON] | en_rise) & ~off_cmd & ~off_pin; // RL6 RL8 RL14
  assign qstop_req = cmd_rise[CB_QSTOP]; // RL9
  assign fclr_cmd  = cmd_rise[CB_FCLR] & ~qstop_req
                   & ~(severe23_q & cmd_data[CB_POWER_ON]); // RL15 RL17
  assign fclr_pin  = fr_rise; // RL7

  // Operating state machine; impossible requests fall through unchanged
  always_comb begin
    state_d = state_q; // RL12
    case (state_q)
      ST_START: begin
        if (init_done) state_d = ST_NOT_RDY;
      end
      ST_NOT_RDY: begin
        if (param_done) state_d = ST_SW_DIS;
      end
      ST_SW_DIS: begin
        if (supply_ok) state_d = ST_RDY;
      end
      ST_RDY: begin
        if (supply_lost) state_d = ST_SW_DIS;
        else if (on_req) state_d = ST_SW_ON; // RL23
      end
      ST_SW_ON: begin
        if (off_pin) state_d = ST_SW_DIS;
        else if (off_cmd) state_d = ST_RDY;
        else state_d = ST_OP_EN; // RL23
      end
      ST_OP_EN: begin
        if (err_class1_evt) state_d = ST_QSTOP;
        else if (off_pin) state_d = ST_SW_DIS; // RL6
        else if (off_cmd) state_d = ST_RDY; // RL8 RL13 RL14
        else if (qstop_req) state_d = ST_QSTOP; // RL9
      end
      ST_QSTOP: begin
        if (off_pin || off_cmd) state_d = ST_SW_DIS;
        else if (fclr_cmd || fclr_pin) state_d = ST_OP_EN; // RL24 RL15
      end
      ST_FLT_REAC: begin
        if (err_resp_done) state_d = ST_FAULT;
      end
      ST_FAULT: begin
        if (cause_corrected && fclr_pin) state_d = ST_SW_DIS; // RL7 RL24
        else if (cause_corrected && fclr_cmd) state_d = ST_RDY; // RL9 RL17 RL24
      end
      default: state_d = ST_START;
    endcase
    if (err_severe_evt && state_q != ST_FLT_REAC && state_q != ST_FAULT) begin
      state_d = ST_FLT_REAC;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_START;
    end else begin
      state_q <= state_d;
    end
  end

  // Remember whether the pending fault is class 2 or 3
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      severe23_q <= 1'b0;
    end else if (err_severe_evt && state_q != ST_FLT_REAC && state_q != ST_FAULT) begin
      severe23_q <= err_class23; // RL17
    end else if (state_q == ST_FAULT && state_d != ST_FAULT) begin
      severe23_q <= 1'b0;
    end
  end

  // Halt handling in operation enabled
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      halt_q       <= 1'b0;
      resume_pulse <= 1'b0;
    end else begin
      resume_pulse <= 1'b0;
      if (state_q != ST_OP_EN) begin
        halt_q <= 1'b0;
      end else if (cmd_rise[CB_HSET]) begin
        halt_q <= 1'b1; // RL10 RL16
      end else if (cmd_rise[CB_HCLR] || cmd_rise[CB_RESUME]) begin
        halt_q       <= 1'b0; // RL10
        resume_pulse <= cmd_rise[CB_RESUME];
      end
    end
  end

  // Signal outputs and power stage, aligned with state_q
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      no_fault_out   <= 1'b0;
      active_out     <= 1'b0;
      power_stage_on <= 1'b0;
    end else begin
      no_fault_out   <= (state_d == ST_RDY) || (state_d == ST_SW_ON)
                     || (state_d == ST_OP_EN); // RL1
      active_out     <= (state_d == ST_OP_EN); // RL1
      power_stage_on <= (state_d == ST_OP_EN) || (state_d == ST_QSTOP); // RL23
    end
  end

  assign halt_active = halt_q;

  // State word; reserved bits stay zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      drive_state_word <= STATE_WORD_RST;
    end else begin
      drive_state_word <= STATE_WORD_RST;
      drive_state_word[SW_STATE_LSB +: 4] <= state_code(state_q); // RL2 RL26
      drive_state_word[SW_ERROR_BIT] <= err_detect; // RL3
      drive_state_word[SW_WARN_BIT]  <= warn_detect; // RL4
      drive_state_word[SW_HALT_BIT]  <= halt_q; // RL4
      drive_state_word[SW_INFO_BIT]  <= mode_specific_info; // RL5
      drive_state_word[SW_END_BIT]   <= mode_ended; // RL5
      drive_state_word[SW_MERR_BIT]  <= mode_err; // RL5
    end
  end

  // Mode request on toggle change
  assign mode_new = mode_wr && (mode_data[MS_TOG_BIT] != tog_q); // RL25

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tog_q       <= 1'b0;
      mode_code   <= MODE_CODE_RST;
      mode_action <= 3'h0;
      mode_start  <= 1'b0;
    end else begin
      mode_start <= mode_new; // RL25
      if (mode_new) begin
        tog_q       <= mode_data[MS_TOG_BIT]; // RL25
        mode_code   <= mode_data[MC_MODE_LSB +: 4]; // RL21
        mode_action <= mode_data[MC_ACT_LSB +: 3]; // RL21
      end
    end
  end

  // Rejection flag; a new reject wins over the clear by a new request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reject_q <= 1'b0;
    end else if (mode_reject) begin
      reject_q <= 1'b1; // RL20
    end else if (mode_new) begin
      reject_q <= 1'b0;
    end
  end

  always_comb begin
    mode_state_byte = MODE_STATE_RST;
    mode_state_byte[MC_MODE_LSB +: 4] = mode_code; // RL18 RL26
    mode_state_byte[MS_REF_BIT] = ref_valid; // RL19
    mode_state_byte[MS_REJ_BIT] = reject_q; // RL20
    mode_state_byte[MS_TOG_BIT] = tog_q; // RL20
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  signal_outputs_a: assert property ( // RL1
    no_fault_out == (state_q inside {ST_RDY, ST_SW_ON, ST_OP_EN})
    && active_out == (state_q == ST_OP_EN))
    else $error("signal outputs do not match state");

  state_field_a: assert property ( // RL2
    !$past(reset) |-> drive_state_word[3:0] == state_code($past(state_q))
    && drive_state_word[12:9] == 4'h0 && drive_state_word[5:4] == 2'h0)
    else $error("state word field wrong");

  error_bit_a: assert property ( // RL3
    !$past(reset) |-> drive_state_word[SW_ERROR_BIT] == $past(err_detect))
    else $error("error bit does not follow detection");

  halt_set_a: assert property ( // RL16
    state_q == ST_OP_EN && cmd_rise[CB_HSET] && state_d == ST_OP_EN
    |=> halt_active ##1 drive_state_word[SW_HALT_BIT])
    else $error("set halt lost");

  off_wins_a: assert property ( // RL14
    state_q == ST_RDY && cmd_rise[CB_POWER_OFF] && cmd_rise[CB_POWER_ON]
    |=> state_q != ST_SW_ON)
    else $error("enable taken against disable");

  auto_enable_a: assert property ( // RL23
    state_q == ST_SW_ON && !off_cmd && !off_pin && !err_severe_evt
    |=> state_q == ST_OP_EN && power_stage_on)
    else $error("no automatic pass to operation enabled");

  zero_write_a: assert property ( // RL13
    state_q == ST_OP_EN && cmd_wr && cmd_data == 8'h00 && !err_severe_evt
    && !err_class1_evt && !en_fall |=> state_q == ST_RDY)
    else $error("all-zero write did not disable");

  qstop_wins_a: assert property ( // RL15
    state_q == ST_OP_EN && cmd_rise[CB_QSTOP] && !off_cmd && !off_pin
    && !err_severe_evt |=> state_q == ST_QSTOP)
    else $error("quick stop not taken");

  fclr_block_a: assert property ( // RL17
    state_q == ST_FAULT && severe23_q && cmd_wr && cmd_data[CB_POWER_ON]
    && !fclr_pin |=> state_q == ST_FAULT)
    else $error("fault reset accepted with enable bit set");

  edge_only_a: assert property ( // RL11
    cmd_wr && cmd_data[CB_QSTOP] && cmd_prev_q[CB_QSTOP] |-> !qstop_req)
    else $error("command bit acted without rising change");

  mode_toggle_a: assert property ( // RL25
    mode_wr && mode_data[MS_TOG_BIT] != mode_state_byte[MS_TOG_BIT]
    |=> mode_start && mode_state_byte[MS_TOG_BIT] == $past(mode_data[MS_TOG_BIT])
    ##1 (!mode_start || $past(mode_wr)))
    else $error("mode toggle not acted upon");

endmodule

/* File: fieldbus_master.sv */
`timescale 1ns/1ns
module fieldbus_master (
  input  wire logic ref_clk,
  output logic      cmd_wr,
  output logic [7:0] cmd_data,
  output logic      mode_wr,
  output logic [7:0] mode_data
);
  initial begin
    cmd_wr = 1'b0;
    cmd_data = 8'h00;
    mode_wr = 1'b0;
    mode_data = 8'h00;
  end

  // One-cycle command write, data scrambled once the strobe drops
  task automatic put_cmd(input logic [7:0] v);
    @(posedge ref_clk);
    #5;
    cmd_wr = 1'b1;
    cmd_data = v;
    @(posedge ref_clk);
    #5;
    cmd_wr = 1'b0;
    cmd_data = ~v;
  endtask

  // Mode code, action, then the toggle bit in one write
  task automatic put_mode(input logic [3:0] code, input logic [2:0] act, input logic tog);
    @(posedge ref_clk);
    #5;
    mode_wr = 1'b1;
    mode_data = {tog, act, code};
    @(posedge ref_clk);
    #5;
    mode_wr = 1'b0;
    mode_data = ~{tog, act, code};
  endtask
endmodule

/* File: drive_state_mode_control_tb.sv */
`timescale 1ns/1ns
module drive_state_mode_control_tb;
  import drive_ctl_pkg::*;
  logic ref_clk, reset, enable_pin, fault_reset_pin, cmd_wr, mode_wr;
  logic [7:0] cmd_data, mode_data, mode_state_byte;
  logic init_done, param_done, supply_ok, supply_lost, err_detect, warn_detect;
  logic err_class1_evt, err_severe_evt, err_class23, err_resp_done, cause_corrected;
  logic mode_specific_info, mode_ended, mode_err, ref_valid, mode_reject;
  logic [15:0] drive_state_word;
  logic no_fault_out, active_out, power_stage_on, halt_active, resume_pulse, mode_start;
  logic [3:0] mode_code;
  logic [2:0] mode_action;
  int bad_count, samples_checked, start_count, resume_count;
  logic tog;
  logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};

  fieldbus_master fieldbus_master_inst (.ref_clk(ref_clk), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .mode_wr(mode_wr), .mode_data(mode_data));

  drive_state_mode_control drive_state_mode_control_inst (.ref_clk(ref_clk), .reset(reset),
    .enable_pin(enable_pin), .fault_reset_pin(fault_reset_pin), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .mode_wr(mode_wr), .mode_data(mode_data), .init_done(init_done),
    .param_done(param_done), .supply_ok(supply_ok), .supply_lost(supply_lost),
    .err_detect(err_detect), .warn_detect(warn_detect), .err_class1_evt(err_class1_evt),
    .err_severe_evt(err_severe_evt), .err_class23(err_class23),
    .err_resp_done(err_resp_done), .cause_corrected(cause_corrected),
    .mode_specific_info(mode_specific_info), .mode_ended(mode_ended), .mode_err(mode_err),
    .ref_valid(ref_valid), .mode_reject(mode_reject), .drive_state_word(drive_state_word),
    .mode_state_byte(mode_state_byte), .no_fault_out(no_fault_out),
    .active_out(active_out), .power_stage_on(power_stage_on), .halt_active(halt_active),
    .resume_pulse(resume_pulse), .mode_start(mode_start), .mode_code(mode_code),
    .mode_action(mode_action));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Pulse counters
  always @(posedge ref_clk) begin
    if (mode_start === 1'b1) start_count++;
    if (resume_pulse === 1'b1) resume_count++;
  end

  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_state(input logic [3:0] code);
    for (int i = 0; i < 30; i++) begin
      @(posedge ref_clk);
      #5;
      if (drive_state_word[3:0] === code) return;
    end
    bad_count++;
    $display("BAD t=%0t got=%h exp=%h", $time, drive_state_word[3:0], code);
    end_of_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  task automatic severe(input logic c23);
    err_class23 = c23;
    err_severe_evt = 1'b1;
    cyc(1);
    err_severe_evt = 1'b0;
  endtask

  initial begin
    reset = 1'b1;
    init_done = 1'b0;
    param_done = 1'b0;
    supply_ok = 1'b0;
    supply_lost = 1'b0;
    enable_pin = 1'b0;
    fault_reset_pin = 1'b0;
    err_detect = 1'b0;
    warn_detect = 1'b0;
    err_class1_evt = 1'b0;
    err_severe_evt = 1'b0;
    err_class23 = 1'b0;
    err_resp_done = 1'b0;
    cause_corrected = 1'b0;
    mode_specific_info = 1'b0;
    mode_ended = 1'b0;
    mode_err = 1'b0;
    ref_valid = 1'b0;
    mode_reject = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    start_count = 0;
    resume_count = 0;
    cyc(4);
    reset = 1'b0;
    cyc(3);
    chk(drive_state_word, 16'h0001);
    init_done = 1'b1;
    wait_state(4'h2);
    param_done = 1'b1;
    wait_state(4'h3);
    cyc(2);
    chk(drive_state_word[3:0], 16'h0003);
    supply_ok = 1'b1;
    wait_state(4'h4);
    supply_lost = 1'b1;
    supply_ok = 1'b0;
    wait_state(4'h3);
    supply_lost = 1'b0;
    supply_ok = 1'b1;
    wait_state(4'h4);
    chk({no_fault_out, active_out}, 16'h0002);
    fieldbus_master_inst.put_cmd(8'h03);
    cyc(3);
    chk(drive_state_word[3:0], 16'h0004);
    fieldbus_master_inst.put_cmd(8'h00);
    fieldbus_master_inst.put_cmd(8'h02);
    wait_state(4'h6);
    chk({no_fault_out, active_out, power_stage_on}, 16'h0007);
    fieldbus_master_inst.put_cmd(8'he2);
    cyc(2);
    chk({halt_active, drive_state_word[8], resume_count[3:0]}, 16'h0030);
    fieldbus_master_inst.put_cmd(8'h02);
    fieldbus_master_inst.put_cmd(8'h42);
    cyc(2);
    chk(halt_active, 16'h0000);
    fieldbus_master_inst.put_cmd(8'h22);
    fieldbus_master_inst.put_cmd(8'h02);
    fieldbus_master_inst.put_cmd(8'h82);
    cyc(2);
    chk(resume_count, 16'h0001);
    fieldbus_master_inst.put_cmd(8'h00);
    wait_state(4'h4);
    fieldbus_master_inst.put_cmd(8'h02);
    wait_state(4'h6);
    fieldbus_master_inst.put_cmd(8'h0e);
    cyc(3);
    chk({drive_state_word[3:0], no_fault_out, active_out}, 16'h001c);
    fieldbus_master_inst.put_cmd(8'h02);
    fieldbus_master_inst.put_cmd(8'h0e);
    cyc(3);
    chk(drive_state_word[3:0], 16'h0007);
    fieldbus_master_inst.put_cmd(8'h02);
    fieldbus_master_inst.put_cmd(8'h0a);
    wait_state(4'h6);
    fieldbus_master_inst.put_cmd(8'h06);
    wait_state(4'h7);
    fieldbus_master_inst.put_cmd(8'h00);
    wait_state(4'h3);
    wait_state(4'h4);
    enable_pin = 1'b1;
    wait_state(4'h6);
    err_class1_evt = 1'b1;
    cyc(1);
    err_class1_evt = 1'b0;
    wait_state(4'h7);
    fault_reset_pin = 1'b1;
    wait_state(4'h6);
    fault_reset_pin = 1'b0;
    enable_pin = 1'b0;
    wait_state(4'h3);
    wait_state(4'h4);
    fieldbus_master_inst.put_cmd(8'h02);
    wait_state(4'h6);
    err_resp_done = 1'b1;
    severe(1'b1);
    wait_state(4'h9);
    chk({no_fault_out, active_out}, 16'h0000);
    fieldbus_master_inst.put_cmd(8'h08);
    cyc(3);
    chk(drive_state_word[3:0], 16'h0009);
    cause_corrected = 1'b1;
    fieldbus_master_inst.put_cmd(8'h02);
    fieldbus_master_inst.put_cmd(8'h0a);
    cyc(3);
    chk(drive_state_word[3:0], 16'h0009);
    fieldbus_master_inst.put_cmd(8'h00);
    fieldbus_master_inst.put_cmd(8'h08);
    wait_state(4'h4);
    severe(1'b0);
    wait_state(4'h9);
    fault_reset_pin = 1'b1;
    wait_state(4'h4);
    {err_detect, warn_detect, mode_specific_info, mode_ended, mode_err} = 5'h1f;
    cyc(3);
    chk(drive_state_word, 16'he0c4);
    tog = 1'b0;
    foreach (codes[i]) begin
      tog = ~tog;
      fieldbus_master_inst.put_mode(codes[i], 3'h5, tog);
      #1;
      chk({mode_state_byte, 1'b0, mode_action, mode_code}, {tog, 3'h0, codes[i], 4'h5, codes[i]});
    end
    fieldbus_master_inst.put_mode(4'h2, 3'h1, tog);
    cyc(2);
    chk({start_count[7:0], mode_code, 1'b0, mode_action}, 16'h0575);
    ref_valid = 1'b1;
    mode_reject = 1'b1;
    cyc(1);
    mode_reject = 1'b0;
    cyc(1);
    chk(mode_state_byte, {tog, 7'h67});
    tog = ~tog;
    fieldbus_master_inst.put_mode(4'h4, 3'h0, tog);
    cyc(1);
    chk(mode_state_byte, {tog, 7'h24});
    reset = 1'b1;
    cyc(2);
    chk(drive_state_word, 16'h0000);
    chk({no_fault_out, active_out, power_stage_on, mode_state_byte}, 16'h0020);
    reset = 1'b0;
    wait_state(4'h4);
    end_of_test();
  end
endmodule
